/* File: motor_driver_status_upper.sv */
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "motor_status_params.svh"


module motor_driver_status_upper
  import motor_status_pkg::*;
#(
  parameter int STANDSTILL_CYCLES = `STANDSTILL_CYCLES
) (
  // Clock and reset
  input  wire logic                    SYS_CLK,
  input  wire logic                    NRST,
  // APB slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [11:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // Pins from the power stage
  input  wire logic                    STEP_PULSE,
  input  wire logic                    DRIVER_ENABLE_N,
  input  wire logic                    OPEN_LOAD_A,
  input  wire logic                    OPEN_LOAD_B,
  input  wire logic                    SHORT_DET_A,
  input  wire logic                    SHORT_DET_B,
  input  wire logic                    OT_WARN_DET,
  input  wire logic                    OT_LIMIT_DET,
  // Same-clock chopper logic
  input  wire motor_status_pkg::load_t LOAD_MEASUREMENT_RESULT,
  input  wire motor_status_pkg::cs_t   CURRENT_SCALE,
  input  wire logic                    FULL_STEP_ACTIVE,
  input  wire logic                    COMMUTATION_STALL,
  // Driver control and interrupt
  output logic                         POWER_DRIVER_EN,
  output logic                         IRQ
);

  import motor_status_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic       step_prev;
  logic       step_seen;
  logic       open_a;
  logic       open_b;
  logic       det_a;
  logic       det_b;
  logic       ot_warn;
  logic       ot_limit;
  logic       enable_pin_n;

  // Two stages before any logic looks at a pin
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      pin_meta <= 8'h02;
      pin_sync <= 8'h02;
    end
    else
    begin
      pin_meta <= {OT_LIMIT_DET, OT_WARN_DET, SHORT_DET_B, SHORT_DET_A,
                   OPEN_LOAD_B, OPEN_LOAD_A, DRIVER_ENABLE_N, STEP_PULSE};
      pin_sync <= pin_meta;
    end
  end

  assign enable_pin_n = pin_sync[1];
  assign open_a       = pin_sync[2];
  assign open_b       = pin_sync[3];
  assign det_a        = pin_sync[4];
  assign det_b        = pin_sync[5];
  assign ot_warn      = pin_sync[6];
  assign ot_limit     = pin_sync[7];

  // Step edge detector on the synchronised pin
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      step_prev <= 1'b0;
    else
      step_prev <= pin_sync[0];
  end

  assign step_seen = pin_sync[0] && !step_prev;

  // ----------------------------------------------------------------
  // Standstill detection
  // ----------------------------------------------------------------
  logic standstill;

  standstill_timer #(
    .CYCLES     (STANDSTILL_CYCLES)
  ) u_standstill (
    .clk        (SYS_CLK),
    .nrst       (NRST),
    .step_seen  (step_seen),
    .standstill (standstill)
  );

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [4:0] ctrl;
  logic       sw_off;
  logic       auto_comm;
  logic       wr_en;
  logic       rd_setup;
  reg_sel_t   sel;

  assign wr_en     = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_setup  = PSEL && !PENABLE;
  assign auto_comm = ctrl[`BIT_AUTO_COMM];

  // Zero off-time or a high enable pin turns the bridge off
  assign sw_off = (ctrl[`OFF_TIME_MSB:`OFF_TIME_LSB] == 4'h0) || enable_pin_n;

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      ctrl <= `CTRL_RESET;
    else if (wr_en && sel == SEL_CTRL)
      ctrl <= PWDATA[4:0];
  end

  // ----------------------------------------------------------------
  // Short to ground latches
  // ----------------------------------------------------------------
  logic short_a;
  logic short_b;

  // A fresh detection beats a simultaneous clear
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      short_a <= 1'b0;
      short_b <= 1'b0;
    end
    else
    begin
      short_a <= det_a || (short_a && !sw_off);
      short_b <= det_b || (short_b && !sw_off);
    end
  end

  // ----------------------------------------------------------------
  // Overtemperature lockout
  // ----------------------------------------------------------------
  logic ot_lock;

  // Held until the pre-warning also drops, giving hysteresis
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      ot_lock <= 1'b0;
    else if (ot_limit)
      ot_lock <= 1'b1;
    else if (!ot_warn)
      ot_lock <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Power stage enable
  // ----------------------------------------------------------------
  // Open load is deliberately absent here: it only informs
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      POWER_DRIVER_EN <= 1'b0;
    else
      POWER_DRIVER_EN <= !(sw_off || short_a || short_b || ot_lock);
  end

  // ----------------------------------------------------------------
  // Sampled status fields
  // ----------------------------------------------------------------
  logic  stall;
  cs_t   cs_actual;
  logic  full_step;
  load_t load_result;

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      stall       <= 1'b0;
      cs_actual   <= 5'h00;
      full_step   <= 1'b0;
      load_result <= 10'h000;
    end
    else
    begin
      stall       <= (LOAD_MEASUREMENT_RESULT == 10'h000) ||
                     (auto_comm && COMMUTATION_STALL);
      cs_actual   <= CURRENT_SCALE;
      full_step   <= FULL_STEP_ACTIVE;
      load_result <= LOAD_MEASUREMENT_RESULT;
    end
  end

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------
  logic [31:0] status_word;

  // Every bit not set below, reserved ones included, reads zero
  always_comb
  begin
    status_word                         = 32'h00000000;
    status_word[`BIT_STANDSTILL]        = standstill;
    status_word[`BIT_OPEN_B]            = open_b;
    status_word[`BIT_OPEN_A]            = open_a;
    status_word[`BIT_SHORT_B]           = short_b;
    status_word[`BIT_SHORT_A]           = short_a;
    status_word[`BIT_OT_WARN]           = ot_warn;
    status_word[`BIT_OT_LIMIT]          = ot_limit;
    status_word[`BIT_STALL]             = stall;
    status_word[`CS_MSB:`CS_LSB]        = cs_actual;
    status_word[`BIT_FULL_STEP]         = full_step;
    status_word[`LOAD_MSB:`LOAD_LSB]    = load_result;
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  irq_vec_t irq_status;
  irq_vec_t irq_mask;
  irq_vec_t events;
  irq_vec_t clr;
  logic     stand_prev;
  logic     short_prev;
  logic     warn_prev;
  logic     limit_prev;
  logic     stall_prev;

  // Rising edges of each condition
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      stand_prev <= 1'b0;
      short_prev <= 1'b0;
      warn_prev  <= 1'b0;
      limit_prev <= 1'b0;
      stall_prev <= 1'b0;
    end
    else
    begin
      stand_prev <= standstill;
      short_prev <= short_a || short_b;
      warn_prev  <= ot_warn;
      limit_prev <= ot_limit;
      stall_prev <= stall;
    end
  end

  always_comb
  begin
    events                 = 5'h00;
    events[`EV_STANDSTILL] = standstill && !stand_prev;
    events[`EV_SHORT]      = (short_a || short_b) && !short_prev;
    events[`EV_OT_WARN]    = ot_warn && !warn_prev;
    events[`EV_OT_LIMIT]   = ot_limit && !limit_prev;
    events[`EV_STALL]      = stall && !stall_prev;
  end

  assign clr = (wr_en && sel == SEL_IRQ_STATUS) ? PWDATA[4:0] : 5'h00;

  // Write one to clear; a same-cycle event wins
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      irq_status <= `IRQ_RESET;
    else
      irq_status <= events | (irq_status & ~clr);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      irq_mask <= `IRQ_RESET;
    else if (wr_en && sel == SEL_IRQ_MASK)
      irq_mask <= PWDATA[4:0];
  end

  // Level output, one cycle behind the status bits
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      IRQ <= 1'b0;
    else
      IRQ <= |(irq_status & irq_mask);
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Address decode
  always_comb
  begin
    case (PADDR)
      `ADDR_STATUS:     sel = SEL_STATUS;
      `ADDR_CTRL:       sel = SEL_CTRL;
      `ADDR_IRQ_STATUS: sel = SEL_IRQ_STATUS;
      `ADDR_IRQ_MASK:   sel = SEL_IRQ_MASK;
      default:          sel = SEL_NONE;
    endcase
  end

  // Answer in the first access cycle; status is a read-only word
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end
    else
    begin
      PREADY  <= rd_setup;
      PSLVERR <= rd_setup && (sel == SEL_NONE || (PWRITE && sel == SEL_STATUS));
      if (rd_setup && !PWRITE)
      begin
        case (sel)
          SEL_STATUS:     PRDATA <= status_word;
          SEL_CTRL:       PRDATA <= {27'h0000000, ctrl};
          SEL_IRQ_STATUS: PRDATA <= {27'h0000000, irq_status};
          SEL_IRQ_MASK:   PRDATA <= {27'h0000000, irq_mask};
          default:        PRDATA <= 32'h00000000;
        endcase
      end
      else
        PRDATA <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  a_step_clears_standstill : assert property (
    step_seen |=> !standstill)
    else $error("standstill kept after a step");

  a_open_load_follow : assert property (
    ##3 status_word[`BIT_OPEN_A] == $past(OPEN_LOAD_A, 2))
    else $error("open load A does not follow its pin");

  a_open_no_action : assert property (
    (!sw_off && !short_a && !short_b && !ot_lock) |=> POWER_DRIVER_EN)
    else $error("driver cut without a protective cause");

  a_short_cuts_driver : assert property (
    (short_a || short_b) |=> !POWER_DRIVER_EN)
    else $error("driver still on after short to ground");

  a_short_held : assert property (
    (short_b && !sw_off) |=> short_b [*2] or (short_b ##1 sw_off))
    else $error("short flag dropped while driver enabled");

  a_short_release : assert property (
    (sw_off && !det_a) |=> !short_a)
    else $error("short flag not cleared by driver disable");

  a_ot_lock_hold : assert property (
    (ot_lock && ot_warn) |=> ot_lock ##1 !POWER_DRIVER_EN)
    else $error("overtemperature lock released while warm");

  a_stall_zero : assert property (
    (LOAD_MEASUREMENT_RESULT == 10'h000) |=> status_word[`BIT_STALL])
    else $error("stall not flagged on zero load result");

  a_current_follow : assert property (
    ##1 status_word[`CS_MSB:`CS_LSB] == $past(CURRENT_SCALE))
    else $error("current scale not reported");

  a_full_step_follow : assert property (
    ##1 status_word[`BIT_FULL_STEP] == $past(FULL_STEP_ACTIVE))
    else $error("full step flag not reported");

  a_reserved_zero : assert property (
    status_word[23:21] == 3'h0 && status_word[14:10] == 5'h00)
    else $error("reserved status bits not zero");

  a_apb_answer : assert property (
    rd_setup |=> PREADY ##1 !PREADY)
    else $error("APB answer not one cycle after setup");

  c_short_then_clear : cover property (short_a ##[1:20] !short_a);
  c_standstill_rise  : cover property ($rose(standstill));
  c_stall_irq        : cover property (irq_status[`EV_STALL] && IRQ);
  c_ot_lock_release  : cover property ($fell(ot_lock));

endmodule : motor_driver_status_upper

/* File: motor_status_params.svh */
`ifndef MOTOR_STATUS_PARAMS_SVH
`define MOTOR_STATUS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_STATUS      12'h000
`define ADDR_CTRL        12'h004
`define ADDR_IRQ_STATUS  12'h008
`define ADDR_IRQ_MASK    12'h00C

// ----------------------------------------------------------------
// Status word field positions
// ----------------------------------------------------------------
`define BIT_STANDSTILL   31
`define BIT_OPEN_B       30
`define BIT_OPEN_A       29
`define BIT_SHORT_B      28
`define BIT_SHORT_A      27
`define BIT_OT_WARN      26
`define BIT_OT_LIMIT     25
`define BIT_STALL        24
`define CS_MSB           20
`define CS_LSB           16
`define BIT_FULL_STEP    15
`define LOAD_MSB         9
`define LOAD_LSB         0

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define OFF_TIME_MSB     3
`define OFF_TIME_LSB     0
`define BIT_AUTO_COMM    4
`define CTRL_RESET       5'h03

// ----------------------------------------------------------------
// Interrupt event positions
// ----------------------------------------------------------------
`define EV_STANDSTILL    0
`define EV_SHORT         1
`define EV_OT_WARN       2
`define EV_OT_LIMIT      3
`define EV_STALL         4
`define IRQ_RESET        5'h00

// ----------------------------------------------------------------
// Timing: step-free clocks before standstill
// ----------------------------------------------------------------
`define STANDSTILL_CYCLES 1048576

`endif

/* File: motor_status_pkg.sv */
package motor_status_pkg;

  // One-hot register select
  typedef enum logic [4:0] {
    SEL_STATUS     = 5'b00001,
    SEL_CTRL       = 5'b00010,
    SEL_IRQ_STATUS = 5'b00100,
    SEL_IRQ_MASK   = 5'b01000,
    SEL_NONE       = 5'b10000
  } reg_sel_t;

  typedef logic [4:0] irq_vec_t;
  typedef logic [4:0] cs_t;
  typedef logic [9:0] load_t;

endpackage : motor_status_pkg

/* File: standstill_timer.sv */
`timescale 1ns/1ps
`include "motor_status_params.svh"

module standstill_timer #(
  parameter int CYCLES = `STANDSTILL_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Step activity and result
  input  wire logic step_seen,
  output logic      standstill
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // ----------------------------------------------------------------
  // Idle counter
  // ----------------------------------------------------------------
  // Stops counting once the flag is set, so the flag holds until the next step
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      count      <= '0;
      standstill <= 1'b0;
    end
    else if (step_seen)
    begin
      count      <= '0;
      standstill <= 1'b0;
    end
    else if (!standstill)
    begin
      count      <= count + CW'(1);
      standstill <= (count == LAST);
    end
  end

  a_flag_on_count : assert property (@(posedge clk) disable iff (!nrst)
    (!step_seen && !standstill && count == LAST) |=> standstill)
    else $error("standstill not set at end of idle count");

  a_flag_early : assert property (@(posedge clk) disable iff (!nrst)
    (standstill && !$past(standstill)) |-> $past(count) == LAST)
    else $error("standstill set before idle count elapsed");

endmodule : standstill_timer

/* File: power_stage_model.sv */
`timescale 1ns/1ps

module power_stage_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Bench requests and bridge state
  input  wire logic [7:0] step_period,
  input  wire logic [5:0] fault,
  input  wire logic       bridge_en,
  // Step and detector pins
  output logic            step_pin,
  output logic            ol_a,
  output logic            ol_b,
  output logic            sh_a,
  output logic            sh_b,
  output logic            ot_w,
  output logic            ot_l
);
  logic [7:0] cnt;

  // ---------------------------------------------
  // Step generator
  // ---------------------------------------------
  // One-cycle pulse per period; pin rests low when stopped
  always_ff @(posedge clk)
  begin
    if (!nrst || step_period == 8'h00)
    begin
      cnt      <= 8'h00;
      step_pin <= 1'b0;
    end
    else
    begin
      cnt      <= (cnt + 8'h01 >= step_period) ? 8'h00 : cnt + 8'h01;
      step_pin <= (cnt == 8'h00);
    end
  end

  // ---------------------------------------------
  // Detectors
  // ---------------------------------------------
  // Open-load sense is a plain level, whatever the bridge does
  assign ol_a = fault[0];
  assign ol_b = fault[1];
  // A short draws current only while driven, so the pin drops once off
  assign sh_a = fault[2] & bridge_en;
  assign sh_b = fault[3] & bridge_en;
  // A die past the limit is past the warning threshold as well
  assign ot_w = fault[4] | fault[5];
  assign ot_l = fault[5];
endmodule : power_stage_model

/* File: motor_driver_status_upper_test.sv */
`timescale 1ns/1ps
`include "motor_status_params.svh"

module motor_driver_status_upper_test;
  import motor_status_pkg::*;

  // ---------------------------------------------
  // Bench state
  // ---------------------------------------------
  localparam int SS = 16;  // Short idle count keeps the run brief
  logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic        drv_en_n, stall_in, full_step, irq, pwr_en;
  logic        step_pin, ol_a, ol_b, sh_a, sh_b, ot_w, ot_l;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  step_period;
  logic [5:0]  fault;
  load_t       load;
  cs_t         cs;
  int          failures, checks_done;
  int          cycles = 0;

  motor_driver_status_upper #(.STANDSTILL_CYCLES(SS)) dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .STEP_PULSE(step_pin),
    .DRIVER_ENABLE_N(drv_en_n), .OPEN_LOAD_A(ol_a), .OPEN_LOAD_B(ol_b),
    .SHORT_DET_A(sh_a), .SHORT_DET_B(sh_b), .OT_WARN_DET(ot_w),
    .OT_LIMIT_DET(ot_l), .LOAD_MEASUREMENT_RESULT(load), .CURRENT_SCALE(cs),
    .FULL_STEP_ACTIVE(full_step), .COMMUTATION_STALL(stall_in),
    .POWER_DRIVER_EN(pwr_en), .IRQ(irq));

  power_stage_model stage (
    .clk(sys_clk), .nrst(nrst), .step_period(step_period), .fault(fault),
    .bridge_en(pwr_en), .step_pin(step_pin), .ol_a(ol_a), .ol_b(ol_b),
    .sh_a(sh_a), .sh_b(sh_b), .ot_w(ot_w), .ot_l(ot_l));

  // ---------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Ceiling far above the roughly three hundred cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures = failures + 1;
      final_report();
    end
  end

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Status read compared under a mask, reserved bits 23:21 and 14:13 checked zero
  task automatic st(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
    check(rd & mask, exp);
    check(rd & 32'h00E0_6000, 32'h0000_0000);
  endtask : st

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // ---------------------------------------------
  // Test sequence
  // ---------------------------------------------
  initial
  begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; drv_en_n = 1'b0;
    stall_in = 1'b0; full_step = 1'b0; load = 10'h155; cs = 5'h00;
    step_period = 8'h00; fault = 6'h00; failures = 0; checks_done = 0;
    // Two cycles of reset; every flop takes its reset value on one edge, synchronisers load 8'h02
    wt(2);
    nrst <= 1'b1;
    // Defaults, dropped bits and refused accesses
    apb(1'b0, `ADDR_CTRL, 32'h0);
    check(rd, {27'h0, `CTRL_RESET});
    apb(1'b0, `ADDR_IRQ_MASK, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b1, `ADDR_STATUS, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, `ADDR_CTRL, 32'hFFFF_FFE3);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_0003);
    $display("done: registers");
    // Standstill after the idle count, cleared by steps, back when idle
    wt(SS + 4);
    st(32'h8000_0000, 32'h8000_0000);
    step_period <= 8'h08;
    wt(40);
    st(32'h8000_0000, 32'h0000_0000);
    step_period <= 8'h00;
    full_step <= 1'b1;
    wt(SS + 8);
    st(32'h8000_0000, 32'h8000_0000);
    full_step <= 1'b0;
    // Interrupt raised, masked, cleared
    apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
    check(rd & 32'h1, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `ADDR_IRQ_MASK, 32'h0000_0011);
    wt(2);
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `ADDR_IRQ_STATUS, 32'h0000_001F);
    wt(2);
    check({31'h0, irq}, 32'h0000_0000);
    $display("done: standstill and interrupt");
    // Open load reported per phase, bridge left running
    // Judged during slow motion only; step gap stays under the idle count
    fault <= 6'h03;
    step_period <= 8'h0C;
    wt(4);
    st(32'h6000_0000, 32'h6000_0000);
    fault <= 6'h02;
    wt(4);
    st(32'h6000_0000, 32'h4000_0000);
    check({31'h0, pwr_en}, 32'h0000_0001);
    step_period <= 8'h00;
    // Short on A latched until off-time goes to zero
    fault <= 6'h04;
    wt(8);
    st(32'h1800_0000, 32'h0800_0000);
    check({31'h0, pwr_en}, 32'h0000_0000);
    fault <= 6'h00;
    wt(6);
    st(32'h1800_0000, 32'h0800_0000);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0000);
    wt(4);
    st(32'h1800_0000, 32'h0000_0000);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0003);
    wt(4);
    // Short on B latched until the enable pin goes high
    fault <= 6'h08;
    wt(8);
    st(32'h1800_0000, 32'h1000_0000);
    fault <= 6'h00;
    drv_en_n <= 1'b1;
    wt(6);
    st(32'h1800_0000, 32'h0000_0000);
    drv_en_n <= 1'b0;
    wt(6);
    check({31'h0, pwr_en}, 32'h0000_0001);
    $display("done: open load and short");
    // Overtemperature lock held until the warning clears too
    fault <= 6'h10;
    wt(4);
    st(32'h0600_0000, 32'h0400_0000);
    fault <= 6'h30;
    wt(6);
    st(32'h0600_0000, 32'h0600_0000);
    check({31'h0, pwr_en}, 32'h0000_0000);
    fault <= 6'h10;
    wt(6);
    check({31'h0, pwr_en}, 32'h0000_0000);
    fault <= 6'h00;
    wt(6);
    check({31'h0, pwr_en}, 32'h0000_0001);
    $display("done: overtemperature");
    // Stall on zero load, and commutation stall only when enabled
    apb(1'b1, `ADDR_IRQ_STATUS, 32'h0000_001F);
    load <= 10'h000;
    wt(3);
    st(32'h0100_03FF, 32'h0100_0000);
    check({31'h0, irq}, 32'h0000_0001);
    load <= 10'h2A5;
    stall_in <= 1'b1;
    wt(3);
    st(32'h0100_03FF, 32'h0000_02A5);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0013);
    wt(3);
    st(32'h0100_0000, 32'h0100_0000);
    stall_in <= 1'b0;
    apb(1'b1, `ADDR_CTRL, 32'h0000_0003);
    $display("done: stall");
    // Current scale and full-step flag across the field range
    for (int i = 0; i < 4; i++)
    begin
      cs <= cs_t'(i * 10 + 1);
      full_step <= i[0];
      wt(2);
      st(32'h001F_8000, (32'(i * 10 + 1) << 16) | (32'(i % 2) << 15));
    end
    $display("done: scale and full step");
    final_report();
  end
endmodule : motor_driver_status_upper_test
